// *** hbgcp_defines.vh ***
/*
  constants of the h-bridge gate control block: register offsets, status
  field positions, reset values and timing counts.
  assumes a 100 mhz system clock and byte addressing on the register bus.
*/
`ifndef HBGCP_DEFINES_VH
`define HBGCP_DEFINES_VH

// clock
`define HBGCP_CLK_PERIOD_NS      10
`define HBGCP_CLK_FREQ_KHZ       100000

// boost oscillator, nominal rate and half period in clock cycles
`define HBGCP_BOOST_FREQ_KHZ     100
`define HBGCP_BOOST_HALF_CYCLES  (`HBGCP_CLK_FREQ_KHZ / `HBGCP_BOOST_FREQ_KHZ / 2)

// cross-conduction dead time, default 1000 ns, least time rounds up
`define HBGCP_DEADTIME_NS        1000
`define HBGCP_DEADTIME_CYCLES    ((`HBGCP_DEADTIME_NS + `HBGCP_CLK_PERIOD_NS - 1) / `HBGCP_CLK_PERIOD_NS)

// short-circuit detection time, default 10000 ns
`define HBGCP_SHORT_NS           10000
`define HBGCP_SHORT_CYCLES       ((`HBGCP_SHORT_NS + `HBGCP_CLK_PERIOD_NS - 1) / `HBGCP_CLK_PERIOD_NS)

// register byte offsets
`define HBGCP_ADDR_DEADTIME      4'h0
`define HBGCP_ADDR_SHORT_TIME    4'h4
`define HBGCP_ADDR_STATUS        4'h8

// status register fields
`define HBGCP_ST_ENABLE          0
`define HBGCP_ST_DIRECTION       1
`define HBGCP_ST_PULSE           2
`define HBGCP_ST_OVERTEMP        3
`define HBGCP_ST_SUPPLY_HIGH     4
`define HBGCP_ST_SUPPLY_LOW      5
`define HBGCP_ST_BOOST           6
`define HBGCP_ST_FAULT           7
`define HBGCP_ST_SHORT_LSB       8

// synchroniser reset pattern: enable low, direction and pulse high
`define HBGCP_SYNC_RESET         10'h006

`endif

// *** hbgcp_boost.v ***
/*
  boost converter switch: hysteretic enable and fixed 50% oscillator.
  assumes start and stop levels already synchronised to clk_sys_i.
*/
`include "hbgcp_defines.vh"

module hbgcp_boost (
  input  wire clk_sys_i,
  input  wire reset_i,
  input  wire start_i,
  input  wire stop_i,
  output reg  active_o,
  output reg  switch_oe_n_o
);

  localparam integer HALF_INT  = `HBGCP_BOOST_HALF_CYCLES - 1;
  localparam [9:0]   HALF_LAST = HALF_INT[9:0];

  reg [9:0] phase_cnt;

  // hysteresis: start below low limit, stop above high limit
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      active_o <= 1'b0;
    end else if (stop_i) begin
      active_o <= 1'b0;
    end else if (start_i) begin
      active_o <= 1'b1;
    end
  end

  // 50% square wave, pulls the pin low in every other half period
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      phase_cnt     <= 10'h000;
      switch_oe_n_o <= 1'b1;
    end else if (!active_o) begin
      phase_cnt     <= 10'h000;
      switch_oe_n_o <= 1'b1;
    end else if (phase_cnt == HALF_LAST) begin
      phase_cnt     <= 10'h000;
      switch_oe_n_o <= ~switch_oe_n_o;
    end else begin
      phase_cnt     <= phase_cnt + 10'h001;
    end
  end

endmodule // hbgcp_boost

// *** hbgcp_gate_channel.v ***
/*
  one gate output: delayed turn-on, immediate turn-off, short detection
  with latch. assumes synchronised inputs and a one-cycle clear pulse.
*/
`include "hbgcp_defines.vh"

module hbgcp_gate_channel (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        want_on_i,
  input  wire        kill_i,
  input  wire [15:0] deadtime_i,
  input  wire [15:0] short_limit_i,
  input  wire        node_bad_i,
  input  wire        short_clear_i,
  output reg         gate_on_o,
  output reg         short_latched_o
);

  reg [15:0] dead_cnt;
  reg [15:0] short_cnt;
  wire       want_eff = want_on_i & ~short_latched_o & ~kill_i;

  // turn-on waits for the dead time, turn-off at once
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gate_on_o <= 1'b0;
      dead_cnt  <= 16'h0000;
    end else if (!want_eff) begin
      gate_on_o <= 1'b0;
      dead_cnt  <= 16'h0000;
    end else if (!gate_on_o) begin
      if (dead_cnt >= deadtime_i) begin
        gate_on_o <= 1'b1;
      end else begin
        dead_cnt  <= dead_cnt + 16'h0001;
      end
    end
  end

  // count consecutive bad-node cycles of a conducting gate
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      short_cnt <= 16'h0000;
    end else if (gate_on_o && node_bad_i && !kill_i) begin
      if (short_cnt != 16'hffff) begin
        short_cnt <= short_cnt + 16'h0001;
      end
    end else begin
      short_cnt <= 16'h0000;
    end
  end

  // latch the shutdown; a new detection wins over the clear
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      short_latched_o <= 1'b0;
    end else if (gate_on_o && node_bad_i && !kill_i && short_cnt >= short_limit_i) begin
      short_latched_o <= 1'b1;
    end else if (short_clear_i) begin
      short_latched_o <= 1'b0;
    end
  end

endmodule // hbgcp_gate_channel

// *** hbgcp_bridge_control.v ***
/*
  h-bridge gate control and protection, top level: input synchronisers,
  fault priority, bridge pattern, four gate channels, boost switch and an
  avalon-mm slave with waitrequest for dead time, short time and status.
  assumes comparator levels from the analog front end, clock of 100 mhz.
*/
// Function
// - boost switch toggles 100kHz, 50% duty
// - boost starts below 8V, stops above 10V
// - active only while enable is high; the boost switch here runs regardless of enable
// - standby: gates resistive, diagnostic released
// - direction and pulse default high
// - pulse 0 drives diagonal pair by direction
// - pulse 1 brakes via both high sides
// - diagnostic high if healthy, low on error
// - overtemp: gates sink, serial off, diag low
// - overvoltage: gates sink, serial off, diag low
// - undervoltage: gates sink, diagnostic low
// - high side off after long low node
// - low side off after long high node
// - shorted gate stays off until input change
// - only the shorted transistor turns off
// - diagnostic combines four sources, real time
// - turn-on delayed by dead time, off immediate
`include "hbgcp_defines.vh"

module hbgcp_bridge_control (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  // host control inputs
  input  wire        enable_i,
  input  wire        direction_i,
  input  wire        pulse_width_i,
  // comparator flags from the analog side
  input  wire        overtemp_flag_i,
  input  wire        supply_high_flag_i,
  input  wire        supply_low_flag_i,
  input  wire        boost_start_i,
  input  wire        boost_stop_i,
  input  wire        bridge_node_a_above_i,
  input  wire        bridge_node_b_above_i,
  // gate drive
  output wire        high_gate_a_o,
  output wire        low_gate_a_o,
  output wire        high_gate_b_o,
  output wire        low_gate_b_o,
  output reg         gate_resistive_o,
  // open-drain pins and serial transmitter gating
  output reg         fault_indicator_n_o,
  output reg         fault_indicator_n_oe_n_o,
  output wire        boost_switch_out_o,
  output wire        boost_switch_out_oe_n_o,
  output reg         serial_tx_enable_o,
  // avalon-mm slave
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o
);

  // reset counts are worked out as integers, then cut to the field width
  localparam integer DEADTIME_INT = `HBGCP_DEADTIME_CYCLES;
  localparam integer SHORT_INT    = `HBGCP_SHORT_CYCLES;
  localparam [15:0]  DEADTIME_RST = DEADTIME_INT[15:0];
  localparam [15:0]  SHORT_RST    = SHORT_INT[15:0];
  localparam [9:0]  SYNC_RST     = `HBGCP_SYNC_RESET;

  // gate index order in vectors: high a, low a, high b, low b
  localparam IDX_HA = 0;
  localparam IDX_LA = 1;
  localparam IDX_HB = 2;
  localparam IDX_LB = 3;

  // merge the two low byte lanes of a write into a 16-bit field
  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0]  be;
    begin
      merge16[7:0]  = be[0] ? wdata[7:0]  : old_val[7:0];
      merge16[15:8] = be[1] ? wdata[15:8] : old_val[15:8];
    end
  endfunction

  // two-stage synchroniser for all asynchronous levels
  // reset values match the idle pins: enable low, direction and pulse high
  reg  [9:0] sync_meta;
  reg  [9:0] sync_q;
  wire [9:0] raw_in = {bridge_node_b_above_i, bridge_node_a_above_i, boost_stop_i, boost_start_i,
                       supply_low_flag_i, supply_high_flag_i, overtemp_flag_i,
                       pulse_width_i, direction_i, enable_i};

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sync_meta <= SYNC_RST;
      sync_q    <= SYNC_RST;
    end else begin
      sync_meta <= raw_in;
      sync_q    <= sync_meta;
    end
  end

  wire en_s       = sync_q[0];
  wire dir_s      = sync_q[1];
  wire pwm_s      = sync_q[2];
  wire hot_s      = sync_q[3];
  wire high_v_s   = sync_q[4];
  wire low_v_s    = sync_q[5];
  wire bst_on_s   = sync_q[6];
  wire bst_off_s  = sync_q[7];
  wire node_a_s   = sync_q[8];
  wire node_b_s   = sync_q[9];

  // previous direction and pulse levels, for change detection
  reg dir_prev;
  reg pwm_prev;

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      dir_prev <= 1'b1;
      pwm_prev <= 1'b1;
    end else begin
      dir_prev <= dir_s;
      pwm_prev <= pwm_s;
    end
  end

  // a change of either input, or standby, frees latched shorts
  // a clear and a new detection in one cycle: the channel lets detection win
  wire short_clear = (dir_s ^ dir_prev) | (pwm_s ^ pwm_prev) | ~en_s;

  // global faults, in priority order, each forces every gate to sink
  reg [1:0] next_fault_cause;
  always @* begin
    if (hot_s) begin
      next_fault_cause = 2'h1;
    end else if (high_v_s) begin
      next_fault_cause = 2'h2;
    end else if (low_v_s) begin
      next_fault_cause = 2'h3;
    end else begin
      next_fault_cause = 2'h0;
    end
  end

  wire global_fault = (next_fault_cause != 2'h0);
  // standby and global faults act at once, turn-off needs no dead time
  wire kill         = ~en_s | global_fault;

  // wanted bridge pattern from direction and pulse
  reg [3:0] want_on;
  always @* begin
    want_on = 4'h0;
    if (pwm_s) begin
      want_on[IDX_HA] = 1'b1;
      want_on[IDX_HB] = 1'b1;
    end else if (!dir_s) begin
      want_on[IDX_LA] = 1'b1;
      want_on[IDX_HB] = 1'b1;
    end else begin
      want_on[IDX_HA] = 1'b1;
      want_on[IDX_LB] = 1'b1;
    end
  end

  // a high side is bad when its node stays low, a low side when high
  // node levels lag the gates by the two synchroniser stages, so a short
  // limit below two cycles would trip on every turn-on
  wire [3:0] node_bad = {node_b_s, ~node_b_s, node_a_s, ~node_a_s};

  // software registers
  reg [15:0] deadtime;
  reg [15:0] short_limit;

  wire [3:0] gate_on;
  wire [3:0] short_latched;

  // one channel per transistor; each latches only its own short
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_chan
      hbgcp_gate_channel u_chan (
        .clk_sys_i       (clk_sys_i),
        .reset_i         (reset_i),
        .want_on_i       (want_on[g]),
        .kill_i          (kill),
        .deadtime_i      (deadtime),
        .short_limit_i   (short_limit),
        .node_bad_i      (node_bad[g]),
        .short_clear_i   (short_clear),
        .gate_on_o       (gate_on[g]),
        .short_latched_o (short_latched[g])
      );
    end
  endgenerate

  assign high_gate_a_o = gate_on[IDX_HA];
  assign low_gate_a_o  = gate_on[IDX_LA];
  assign high_gate_b_o = gate_on[IDX_HB];
  assign low_gate_b_o  = gate_on[IDX_LB];

  wire any_short = |short_latched;
  wire any_fault = global_fault | any_short;

  // diagnostic pin, resistive gate state and serial gating
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gate_resistive_o         <= 1'b1;
      fault_indicator_n_o      <= 1'b1;
      fault_indicator_n_oe_n_o <= 1'b1;
      serial_tx_enable_o       <= 1'b0;
    end else if (!en_s) begin
      gate_resistive_o         <= 1'b1;
      fault_indicator_n_o      <= 1'b1;
      fault_indicator_n_oe_n_o <= 1'b1;
      serial_tx_enable_o       <= 1'b0;
    end else begin
      gate_resistive_o         <= 1'b0;
      fault_indicator_n_o      <= ~any_fault;
      fault_indicator_n_oe_n_o <= 1'b0;
      serial_tx_enable_o       <= ~(hot_s | high_v_s);
    end
  end

  // boost converter switch
  wire boost_active;

  hbgcp_boost u_boost (
    .clk_sys_i     (clk_sys_i),
    .reset_i       (reset_i),
    .start_i       (bst_on_s),
    .stop_i        (bst_off_s),
    .active_o      (boost_active),
    .switch_oe_n_o (boost_switch_out_oe_n_o)
  );

  // open drain: the pin only ever pulls low
  assign boost_switch_out_o = 1'b0;

  // status word showing the block's own state, one field per define
  reg [31:0] status_word;
  always @* begin
    status_word                           = 32'h00000000;
    status_word[`HBGCP_ST_ENABLE]         = en_s;
    status_word[`HBGCP_ST_DIRECTION]      = dir_s;
    status_word[`HBGCP_ST_PULSE]          = pwm_s;
    status_word[`HBGCP_ST_OVERTEMP]       = hot_s;
    status_word[`HBGCP_ST_SUPPLY_HIGH]    = high_v_s;
    status_word[`HBGCP_ST_SUPPLY_LOW]     = low_v_s;
    status_word[`HBGCP_ST_BOOST]          = boost_active;
    status_word[`HBGCP_ST_FAULT]          = any_fault;
    status_word[`HBGCP_ST_SHORT_LSB +: 4] = short_latched;
  end

  wire bus_req = avs_read_i | avs_write_i;

  // an access is taken while waitrequest is high and answered a cycle later;
  // a master that keeps its request past the answer starts a second access
  // one wait cycle per access; the write lands on the accepting edge
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
      deadtime          <= DEADTIME_RST;
      short_limit       <= SHORT_RST;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      case (avs_address_i)
        `HBGCP_ADDR_DEADTIME: begin
          avs_readdata_o <= {16'h0000, deadtime};
        end
        `HBGCP_ADDR_SHORT_TIME: begin
          avs_readdata_o <= {16'h0000, short_limit};
        end
        `HBGCP_ADDR_STATUS: begin
          avs_readdata_o <= status_word;
        end
        default: begin
          avs_readdata_o <= 32'h00000000;
        end
      endcase
    end else begin
      avs_waitrequest_o <= 1'b1;
      if (bus_req && avs_write_i) begin
        case (avs_address_i)
          `HBGCP_ADDR_DEADTIME: begin
            deadtime <= merge16(deadtime, avs_writedata_i, avs_byteenable_i);
          end
          `HBGCP_ADDR_SHORT_TIME: begin
            short_limit <= merge16(short_limit, avs_writedata_i, avs_byteenable_i);
          end
          default: begin
            deadtime <= deadtime;
          end
        endcase
      end
    end
  end

endmodule // hbgcp_bridge_control

// *** hbgcp_checker.sv ***
/* port checker for the bridge control block.
   assumes one clock domain and a bind onto hbgcp_bridge_control. */
module hbgcp_checker (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic direction_i,
  input wire logic pulse_width_i,
  input wire logic overtemp_flag_i,
  input wire logic supply_high_flag_i,
  input wire logic supply_low_flag_i,
  input wire logic boost_start_i,
  input wire logic boost_stop_i,
  input wire logic high_gate_a_o,
  input wire logic low_gate_a_o,
  input wire logic high_gate_b_o,
  input wire logic low_gate_b_o,
  input wire logic gate_resistive_o,
  input wire logic fault_indicator_n_o,
  input wire logic fault_indicator_n_oe_n_o,
  input wire logic boost_switch_out_oe_n_o,
  input wire logic serial_tx_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire logic       any_gate = high_gate_a_o | low_gate_a_o | high_gate_b_o | low_gate_b_o;
  logic      [9:0] low_cnt;
  // length of the current low half of the boost switch
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i)
      low_cnt <= 10'h000;
    else if (boost_switch_out_oe_n_o)
      low_cnt <= 10'h000;
    else
      low_cnt <= low_cnt + 10'h001;
  end
  a_standby_released: assert property (!enable_i [*5] |-> !any_gate && gate_resistive_o && fault_indicator_n_oe_n_o)
    else $error("standby outputs wrong");
  a_overtemp_sink: assert property ((enable_i && overtemp_flag_i) [*5] |->
    !any_gate && !fault_indicator_n_o && !serial_tx_enable_o) else $error("overtemp outputs wrong");
  a_overvolt_sink: assert property ((enable_i && supply_high_flag_i) [*5] |->
    !any_gate && !fault_indicator_n_o && !serial_tx_enable_o) else $error("overvoltage outputs wrong");
  a_undervolt_sink: assert property ((enable_i && supply_low_flag_i) [*5] |-> !any_gate && !fault_indicator_n_o)
    else $error("undervoltage outputs wrong");
  a_dir_zero_off: assert property ((enable_i && !direction_i && !pulse_width_i) [*5] |-> !high_gate_a_o && !low_gate_b_o)
    else $error("direction 0 pattern wrong");
  a_dir_one_off: assert property ((enable_i && direction_i && !pulse_width_i) [*5] |-> !low_gate_a_o && !high_gate_b_o)
    else $error("direction 1 pattern wrong");
  a_brake_lows_off: assert property ((enable_i && pulse_width_i) [*5] |-> !low_gate_a_o && !low_gate_b_o)
    else $error("brake low sides on");
  a_half_a_gap: assert property ($rose(high_gate_a_o) || $rose(low_gate_a_o) |->
    !$past(high_gate_a_o) && !$past(low_gate_a_o)) else $error("half bridge a turned on without gap");
  a_turn_on_enabled: assert property ($rose(any_gate) |-> $past(enable_i, 5))
    else $error("gate on too soon after enable");
  a_boost_stop_idle: assert property (boost_stop_i [*6] |-> boost_switch_out_oe_n_o)
    else $error("boost switch runs after stop");
  a_boost_low_half: assert property ($rose(boost_switch_out_oe_n_o) && boost_start_i |-> low_cnt == 10'h1f4)
    else $error("boost low half length wrong");
  a_boost_low_max: assert property (low_cnt <= 10'h1f4)
    else $error("boost low half too long");
endmodule // hbgcp_checker

bind hbgcp_bridge_control hbgcp_checker u_checker (.*);

// *** hbgcp_host_model.sv ***
/* host model: drives enable, direction and pulse width.
   assumes its tasks are called from the bench on clk_sys_i. */
module hbgcp_host_model (
  input  wire logic clk_sys_i,
  output logic      enable_o,
  output logic      direction_o,
  output logic      pulse_width_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels: disabled, both inputs high
  initial begin
    enable_o = 1'b0;
    {direction_o, pulse_width_o} = 2'h3;
  end
  // new direction and pulse level after an edge
  task automatic drive(input logic dir, input logic pwm);
    @(posedge clk_sys_i);
    direction_o <= dir;
    pulse_width_o <= pwm;
  endtask
  // inputs high, enable, then settle time
  task automatic wake();
    drive(1'b1, 1'b1);
    @(posedge clk_sys_i);
    enable_o <= 1'b1;
    repeat (5000) @(posedge clk_sys_i);
  endtask
  // inputs high before enable drops
  task automatic sleep();
    drive(1'b1, 1'b1);
    @(posedge clk_sys_i);
    enable_o <= 1'b0;
  endtask
endmodule // hbgcp_host_model

// *** tb_hbgcp_bridge_control.sv ***
/* bench for the bridge control: bus tasks, host model, fault and
   short injection. assumes the checker is bound to the design. */
`include "hbgcp_defines.vh"
module tb_hbgcp_bridge_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i, reset_i, overtemp_flag_i, supply_high_flag_i, supply_low_flag_i;
  logic        boost_start_i, boost_stop_i, avs_read_i, avs_write_i, bat_a, gnd_b;
  logic [3:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i, q;
  wire  [31:0] avs_readdata_o;
  wire         enable_i, direction_i, pulse_width_i, avs_waitrequest_o, serial_tx_enable_o;
  wire         high_gate_a_o, low_gate_a_o, high_gate_b_o, low_gate_b_o, gate_resistive_o;
  wire         fault_indicator_n_o, fault_indicator_n_oe_n_o, boost_switch_out_o, boost_switch_out_oe_n_o;
  wire         bridge_node_a_above_i = high_gate_a_o | bat_a;
  wire         bridge_node_b_above_i = high_gate_b_o & !gnd_b;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  logic [9:0]  pat [4] = '{10'h026, 10'h209, 10'h38a, 10'h1aa};
  logic [2:0]  fl [4] = '{3'h4, 3'h2, 3'h1, 3'h5};
  hbgcp_host_model host (.clk_sys_i(clk_sys_i), .enable_o(enable_i), .direction_o(direction_i),
    .pulse_width_o(pulse_width_i));
  hbgcp_bridge_control dut (.*);
  // clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_gates(input string what, input logic [3:0] exp);
    chk(what, {28'h0, exp}, {28'h0, high_gate_a_o, low_gate_a_o, high_gate_b_o, low_gate_b_o});
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  // one bus access, held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 40);
    if (avs_waitrequest_o !== 1'b0) begin
      fails++;
      finish_test();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  // length of the next boost half at level lvl
  task automatic half(input logic lvl, output int k);
    k = 0;
    while (boost_switch_out_oe_n_o !== lvl && k < 2000) begin
      tick(1);
      k++;
    end
    k = 0;
    while (boost_switch_out_oe_n_o === lvl && k < 2000) begin
      tick(1);
      k++;
    end
  endtask
  // main sequence
  initial begin
    reset_i = 1'b1;
    {avs_read_i, avs_write_i, overtemp_flag_i, supply_high_flag_i, supply_low_flag_i} = 5'h00;
    {boost_start_i, boost_stop_i, bat_a, gnd_b, avs_address_i, avs_writedata_i} = '0;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    tick(1);
    chk_gates("gates after reset", 4'h0);
    chk("diag released", 1, fault_indicator_n_oe_n_o);
    rd_chk(`HBGCP_ADDR_STATUS, 32'h0000_0006, "status idle");
    rd_chk(`HBGCP_ADDR_DEADTIME, 32'h0000_0064, "dead time reset");
    rd_chk(`HBGCP_ADDR_SHORT_TIME, 32'h0000_03e8, "short limit reset");
    bus(1'b1, `HBGCP_ADDR_DEADTIME, 32'hffff_0002);
    bus(1'b1, `HBGCP_ADDR_SHORT_TIME, 32'h0000_0003);
    bus(1'b1, 4'hc, 32'h0000_00ff);
    rd_chk(4'hc, 32'h0, "unmapped read");
    rd_chk(`HBGCP_ADDR_DEADTIME, 32'h0000_0002, "dead time written");
    host.drive(1'b0, 1'b0);
    tick(8);
    chk_gates("standby gates", 4'h0);
    chk("standby resistive", 1, gate_resistive_o);
    $display("test registers and standby finished");
    host.wake();
    tick(1);
    chk("resistive enabled", 0, gate_resistive_o);
    chk("diag healthy", 1, fault_indicator_n_o);
    chk("diag driven", 0, fault_indicator_n_oe_n_o);
    chk("serial enabled", 1, serial_tx_enable_o);
    chk_gates("brake on wake", 4'ha);
    rd_chk(`HBGCP_ADDR_STATUS, 32'h0000_0007, "status");
    foreach (pat[i]) begin
      host.drive(pat[i][9], pat[i][8]);
      tick(5);
      chk_gates("gates in dead time", pat[i][7:4]);
      tick(2);
      chk_gates("gates settled", pat[i][3:0]);
    end
    $display("test drive patterns finished");
    foreach (fl[i]) begin
      @(posedge clk_sys_i);
      {overtemp_flag_i, supply_high_flag_i, supply_low_flag_i} <= fl[i];
      tick(5);
      chk_gates("gates in fault", 4'h0);
      chk("diag in fault", 0, fault_indicator_n_o);
      if (fl[i][2] || fl[i][1])
        chk("serial in fault", 0, serial_tx_enable_o);
      @(posedge clk_sys_i);
      {overtemp_flag_i, supply_high_flag_i, supply_low_flag_i} <= 3'h0;
      tick(4);
      chk("diag after fault", 1, fault_indicator_n_o);
      tick(4);
      chk_gates("gates after fault", 4'ha);
    end
    $display("test global faults finished");
    // high side b shorted to ground, then low side a to supply
    host.drive(1'b0, 1'b0);
    gnd_b <= 1'b1;
    tick(16);
    chk_gates("high b shorted", 4'h4);
    chk("diag high short", 0, fault_indicator_n_o);
    @(posedge clk_sys_i);
    gnd_b <= 1'b0;
    tick(10);
    chk_gates("high b stays off", 4'h4);
    host.drive(1'b0, 1'b1);
    tick(8);
    chk_gates("cleared by pulse", 4'ha);
    chk("diag cleared", 1, fault_indicator_n_o);
    host.drive(1'b0, 1'b0);
    bat_a <= 1'b1;
    tick(16);
    chk_gates("low a shorted", 4'h2);
    chk("diag low short", 0, fault_indicator_n_o);
    @(posedge clk_sys_i);
    bat_a <= 1'b0;
    host.drive(1'b1, 1'b0);
    tick(8);
    chk_gates("cleared by direction", 4'h9);
    chk("diag after clear", 1, fault_indicator_n_o);
    $display("test short circuit finished");
    @(posedge clk_sys_i);
    boost_start_i <= 1'b1;
    half(1'b0, n);
    chk("boost low half", 500, n);
    half(1'b1, n);
    chk("boost high half", 500, n);
    chk("boost pin level", 0, boost_switch_out_o);
    @(posedge clk_sys_i);
    boost_start_i <= 1'b0;
    boost_stop_i <= 1'b1;
    tick(8);
    chk("boost stopped", 1, boost_switch_out_oe_n_o);
    @(posedge clk_sys_i);
    boost_stop_i <= 1'b0;
    n = 0;
    repeat (1100) begin
      tick(1);
      n += (boost_switch_out_oe_n_o !== 1'b1);
    end
    chk("boost idle lows", 0, n);
    $display("test boost finished");
    host.sleep();
    tick(5);
    chk_gates("gates after sleep", 4'h0);
    chk("resistive after sleep", 1, gate_resistive_o);
    chk("diag after sleep", 1, fault_indicator_n_oe_n_o);
    $display("test sleep finished");
    finish_test();
  end
endmodule // tb_hbgcp_bridge_control
